// ==== hdl/qpd_pkg.sv ====
/*
 constants, types and coding helpers shared by both ends of the quad-pumped data bus.
 assumes ref_clk at 20 mhz and a bus clock of 400 ns that comes from outside.
*/
// Function
// - 64-bit shared bidirectional data path, all agents
// - driver asserts data valid during transfers
// - four transfers per bus clock period
// - capture on both strobe falling edges
// - four 16-bit groups, group n on pair n
// - one inversion flag per group, same index
// - flags travel with data, same strobes
// - flag asserted whenever group is inverted
// - flagged group read active high
// - optional inversion when over half lines low
package qpd_pkg;
   localparam int QPD_DATA_W = 64;
   localparam int QPD_GROUPS = 4;
   localparam int QPD_GROUP_W = 16;
   localparam int QPD_BEATS = 4;
   localparam int QPD_FIFO_DEPTH = 2;
   localparam logic [4:0] QPD_LOW_LIMIT = 5'h08;
   localparam int QPD_REF_PERIOD_NS = 50;
   localparam int QPD_BUS_PERIOD_NS = 400;
   localparam int QPD_PHASE_CYC = QPD_BUS_PERIOD_NS / QPD_REF_PERIOD_NS;
   localparam logic [2:0] QPD_LAST_CYC = 3'(QPD_PHASE_CYC - 1);
   localparam logic [2:0] QPD_CNT_RST = 3'h0;
   localparam logic [2:0] QPD_FILL_LAST = 3'(QPD_BEATS - 1);
   localparam logic [2:0] QPD_BEAT_DONE = 3'(QPD_BEATS);
   localparam logic [1:0] QPD_FIFO_FULL = 2'(QPD_FIFO_DEPTH);

   typedef logic [QPD_DATA_W-1:0] qpd_word_t;
   typedef logic [QPD_GROUPS+QPD_DATA_W-1:0] qpd_enc_t;

   typedef enum logic [2:0]
   {
      QPD_TX_GATHER = 3'b001,
      QPD_TX_WAIT = 3'b010,
      QPD_TX_SEND = 3'b100
   } qpd_tx_t;

   typedef struct packed
   {
      logic clk;
      logic valid_n;
      logic [QPD_GROUPS-1:0] stn_n;
      logic [QPD_GROUPS-1:0] stp_n;
      logic [QPD_GROUPS-1:0] flag_n;
      logic [QPD_DATA_W-1:0] data_n;
   } qpd_pins_t;

   function automatic logic [4:0] qpd_low_count(input logic [QPD_GROUP_W-1:0] d);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < QPD_GROUP_W; i++)
      begin
         n = n + {4'h0, d[i]};
      end
      return n;
   endfunction

   // same mapping both ways: lines are active low unless the group is inverted
   function automatic logic [QPD_GROUP_W-1:0] qpd_polarity(input logic [QPD_GROUP_W-1:0] v,
                                                           input logic inv);
      return inv ? v : ~v;
   endfunction

   // a logical one drives a line low, so the ones counted are the low lines
   function automatic qpd_enc_t qpd_encode(input qpd_word_t w, input logic [QPD_GROUPS-1:0] en);
      qpd_enc_t r;
      logic inv;
      r = '0;
      for (int g = 0; g < QPD_GROUPS; g++)
      begin
         inv = en[g] & (qpd_low_count(w[g*QPD_GROUP_W +: QPD_GROUP_W]) > QPD_LOW_LIMIT);
         r[g*QPD_GROUP_W +: QPD_GROUP_W] = qpd_polarity(w[g*QPD_GROUP_W +: QPD_GROUP_W], inv);
         r[QPD_DATA_W+g] = ~inv;
      end
      return r;
   endfunction

   function automatic logic qpd_pos_low(input logic [2:0] n);
      return (n[1:0] == 2'h1) | (n[1:0] == 2'h2);
   endfunction

   function automatic logic qpd_neg_low(input logic [2:0] n);
      return (n[1:0] == 2'h3) | (n == 3'h4);
   endfunction
endpackage

// ==== hdl/qpd_fsb_if.sv ====
/*
 the shared data-phase lines between the processor end and the chipset end.
 assumes each end drives its outputs only while its enable is low; lines pull high.
*/
`timescale 1ns/100ps
`default_nettype none
interface qpd_fsb_if
(
   input wire logic bus_clk
);
   import qpd_pkg::*;
   qpd_word_t p_data_n_o;
   qpd_word_t c_data_n_o;
   logic [QPD_GROUPS-1:0] p_flag_n_o;
   logic [QPD_GROUPS-1:0] c_flag_n_o;
   logic [QPD_GROUPS-1:0] p_stp_n_o;
   logic [QPD_GROUPS-1:0] c_stp_n_o;
   logic [QPD_GROUPS-1:0] p_stn_n_o;
   logic [QPD_GROUPS-1:0] c_stn_n_o;
   logic p_valid_n_o;
   logic c_valid_n_o;
   logic p_oe_n;
   logic c_oe_n;
   qpd_word_t fsb_data_n;
   logic [QPD_GROUPS-1:0] group_invert_flag_n;
   logic [QPD_GROUPS-1:0] data_strobe_pos_n;
   logic [QPD_GROUPS-1:0] data_strobe_neg_n;
   logic data_valid_indicator_n;

   // wired-and of both ends: every agent sits on the same lines
   assign fsb_data_n = (p_oe_n ? '1 : p_data_n_o) & (c_oe_n ? '1 : c_data_n_o);
   assign group_invert_flag_n = (p_oe_n ? '1 : p_flag_n_o) & (c_oe_n ? '1 : c_flag_n_o);
   assign data_strobe_pos_n = (p_oe_n ? '1 : p_stp_n_o) & (c_oe_n ? '1 : c_stp_n_o);
   assign data_strobe_neg_n = (p_oe_n ? '1 : p_stn_n_o) & (c_oe_n ? '1 : c_stn_n_o);
   assign data_valid_indicator_n = (p_oe_n | p_valid_n_o) & (c_oe_n | c_valid_n_o);

   modport proc
   (
      input bus_clk, fsb_data_n, group_invert_flag_n, data_strobe_pos_n, data_strobe_neg_n,
      input data_valid_indicator_n,
      output p_data_n_o, p_flag_n_o, p_stp_n_o, p_stn_n_o, p_valid_n_o, p_oe_n
   );

   modport chip
   (
      input bus_clk, fsb_data_n, group_invert_flag_n, data_strobe_pos_n, data_strobe_neg_n,
      input data_valid_indicator_n,
      output c_data_n_o, c_flag_n_o, c_stp_n_o, c_stn_n_o, c_valid_n_o, c_oe_n
   );
endinterface
`default_nettype wire

// ==== hdl/qpd_proc_end.sv ====
/*
 processor end of the quad-pumped data bus: transmit buffer, four-beat staging,
 source-synchronous driver with per-group inversion, and strobe-timed receiver.
 assumes the bus clock runs at eight ref_clk periods and that bus_grant is never
 high at both ends in the same phase; arbitration lives elsewhere.
*/
`timescale 1ns/100ps
`default_nettype none
module qpd_proc_end
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // bus lines
   qpd_fsb_if.proc fsb,
   // transmit side
   input wire qpd_pkg::qpd_word_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic bus_grant,
   input wire logic [qpd_pkg::QPD_GROUPS-1:0] inv_en,
   // receive side
   output qpd_pkg::qpd_word_t rx_data,
   output logic rx_valid
);
   import qpd_pkg::*;

   qpd_pins_t pin_raw;
   qpd_pins_t pin_s1_reg;
   qpd_pins_t pin_s2_reg;
   logic clk_s3_reg;
   logic [QPD_GROUPS-1:0] stp_s3_reg;
   logic [QPD_GROUPS-1:0] stn_s3_reg;
   logic bus_edge;

   qpd_word_t fifo_mem [QPD_FIFO_DEPTH];
   logic fifo_wr_reg;
   logic fifo_rd_reg;
   logic [1:0] fifo_cnt_reg;
   logic fifo_push;
   logic fifo_pop;

   qpd_word_t stage_mem [QPD_BEATS];
   logic [2:0] fill_reg;
   qpd_tx_t tx_state_reg;
   logic start;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;

   qpd_word_t drv_data_reg;
   logic [QPD_GROUPS-1:0] drv_flag_reg;
   logic [QPD_GROUPS-1:0] drv_stp_reg;
   logic [QPD_GROUPS-1:0] drv_stn_reg;
   logic drv_valid_n_reg;
   logic drv_oe_n_reg;
   logic own_reg;

   qpd_word_t rx_word [QPD_BEATS];
   logic [2:0] grp_cnt_reg [QPD_GROUPS];
   logic [2:0] out_idx_reg;
   logic [QPD_GROUPS-1:0] take;
   logic rx_pending;
   logic rx_clear;
   qpd_word_t rx_data_reg;
   logic rx_valid_reg;

   // every pin, the bus clock included, crosses through two flops
   assign pin_raw.clk = fsb.bus_clk;
   assign pin_raw.valid_n = fsb.data_valid_indicator_n;
   assign pin_raw.stn_n = fsb.data_strobe_neg_n;
   assign pin_raw.stp_n = fsb.data_strobe_pos_n;
   assign pin_raw.flag_n = fsb.group_invert_flag_n;
   assign pin_raw.data_n = fsb.fsb_data_n;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         pin_s1_reg <= '1;
         pin_s2_reg <= '1;
      end
      else
      begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // edges are found on the second and third stages only
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         clk_s3_reg <= 1'b1;
         stp_s3_reg <= '1;
         stn_s3_reg <= '1;
      end
      else
      begin
         clk_s3_reg <= pin_s2_reg.clk;
         stp_s3_reg <= pin_s2_reg.stp_n;
         stn_s3_reg <= pin_s2_reg.stn_n;
      end
   end

   assign bus_edge = pin_s2_reg.clk & ~clk_s3_reg;

   // two-entry buffer; the staging side stalls it while a phase is pending
   assign tx_ready = fifo_cnt_reg != QPD_FIFO_FULL;
   assign fifo_push = tx_valid & tx_ready;
   assign fifo_pop = (fifo_cnt_reg != 2'h0) & (tx_state_reg == QPD_TX_GATHER);

   always_ff @(posedge ref_clk)
   begin
      if (fifo_push)
      begin
         fifo_mem[fifo_wr_reg] <= tx_data;
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fifo_wr_reg <= 1'b0;
         fifo_rd_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
      end
      else
      begin
         fifo_wr_reg <= fifo_wr_reg ^ fifo_push;
         fifo_rd_reg <= fifo_rd_reg ^ fifo_pop;
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
      end
   end

   // four words are staged so that a phase never starves mid-clock
   always_ff @(posedge ref_clk)
   begin
      if (fifo_pop)
      begin
         stage_mem[fill_reg[1:0]] <= fifo_mem[fifo_rd_reg];
      end
   end

   assign start = (tx_state_reg == QPD_TX_WAIT) & bus_edge & bus_grant;
   assign cnt_next = cnt_reg + 3'h1;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_state_reg <= QPD_TX_GATHER;
         fill_reg <= QPD_CNT_RST;
      end
      else
      begin
         case (tx_state_reg)
            QPD_TX_GATHER:
            begin
               if (fifo_pop)
               begin
                  fill_reg <= fill_reg + 3'h1;
                  if (fill_reg == QPD_FILL_LAST)
                  begin
                     tx_state_reg <= QPD_TX_WAIT;
                  end
               end
            end
            QPD_TX_WAIT:
            begin
               if (start)
               begin
                  tx_state_reg <= QPD_TX_SEND;
               end
            end
            QPD_TX_SEND:
            begin
               if (cnt_reg == QPD_LAST_CYC)
               begin
                  tx_state_reg <= QPD_TX_GATHER;
                  fill_reg <= QPD_CNT_RST;
               end
            end
            default:
            begin
               tx_state_reg <= QPD_TX_GATHER;
            end
         endcase
      end
   end

   // two ref cycles per beat; each strobe falls in the middle of its beat
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg <= QPD_CNT_RST;
         drv_data_reg <= '1;
         drv_flag_reg <= '1;
         drv_stp_reg <= '1;
         drv_stn_reg <= '1;
         drv_valid_n_reg <= 1'b1;
         drv_oe_n_reg <= 1'b1;
      end
      else if (start)
      begin
         cnt_reg <= QPD_CNT_RST;
         {drv_flag_reg, drv_data_reg} <= qpd_encode(stage_mem[0], inv_en);
         drv_stp_reg <= '1;
         drv_stn_reg <= '1;
         drv_valid_n_reg <= 1'b0;
         drv_oe_n_reg <= 1'b0;
      end
      else if ((tx_state_reg == QPD_TX_SEND) && (cnt_reg != QPD_LAST_CYC))
      begin
         cnt_reg <= cnt_next;
         {drv_flag_reg, drv_data_reg} <= qpd_encode(stage_mem[cnt_next[2:1]], inv_en);
         drv_stp_reg <= {QPD_GROUPS{~qpd_pos_low(cnt_next)}};
         drv_stn_reg <= {QPD_GROUPS{~qpd_neg_low(cnt_next)}};
      end
      else if (tx_state_reg == QPD_TX_SEND)
      begin
         drv_stp_reg <= '1;
         drv_stn_reg <= '1;
         drv_valid_n_reg <= 1'b1;
         drv_oe_n_reg <= 1'b1;
      end
   end

   assign fsb.p_data_n_o = drv_data_reg;
   assign fsb.p_flag_n_o = drv_flag_reg;
   assign fsb.p_stp_n_o = drv_stp_reg;
   assign fsb.p_stn_n_o = drv_stn_reg;
   assign fsb.p_valid_n_o = drv_valid_n_reg;
   assign fsb.p_oe_n = drv_oe_n_reg;

   // own echo reaches the receiver late, so it stays masked until the line is idle
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         own_reg <= 1'b0;
      end
      else if (start)
      begin
         own_reg <= 1'b1;
      end
      else if ((tx_state_reg != QPD_TX_SEND) && pin_s2_reg.valid_n)
      begin
         own_reg <= 1'b0;
      end
   end

   always_comb
   begin
      rx_pending = 1'b1;
      for (int g = 0; g < QPD_GROUPS; g++)
      begin
         take[g] = ((stp_s3_reg[g] & ~pin_s2_reg.stp_n[g]) | (stn_s3_reg[g] & ~pin_s2_reg.stn_n[g]))
                   & ~pin_s2_reg.valid_n & ~own_reg & (grp_cnt_reg[g] != QPD_BEAT_DONE);
         rx_pending = rx_pending & (grp_cnt_reg[g] > out_idx_reg);
      end
   end

   assign rx_clear = pin_s2_reg.valid_n & ~rx_pending;

   // each group keeps its own beat count, timed only by its own strobe pair
   always_ff @(posedge ref_clk)
   begin
      for (int g = 0; g < QPD_GROUPS; g++)
      begin
         if (take[g])
         begin
            rx_word[grp_cnt_reg[g][1:0]][g*QPD_GROUP_W +: QPD_GROUP_W] <=
               qpd_polarity(pin_s2_reg.data_n[g*QPD_GROUP_W +: QPD_GROUP_W],
                            ~pin_s2_reg.flag_n[g]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int g = 0; g < QPD_GROUPS; g++)
         begin
            grp_cnt_reg[g] <= QPD_CNT_RST;
         end
      end
      else
      begin
         for (int g = 0; g < QPD_GROUPS; g++)
         begin
            if (rx_clear)
            begin
               grp_cnt_reg[g] <= QPD_CNT_RST;
            end
            else if (take[g])
            begin
               grp_cnt_reg[g] <= grp_cnt_reg[g] + 3'h1;
            end
         end
      end
   end

   // a word leaves once every group has delivered its slice of that beat
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         out_idx_reg <= QPD_CNT_RST;
         rx_data_reg <= '0;
         rx_valid_reg <= 1'b0;
      end
      else if (rx_pending)
      begin
         rx_data_reg <= rx_word[out_idx_reg[1:0]];
         rx_valid_reg <= 1'b1;
         out_idx_reg <= out_idx_reg + 3'h1;
      end
      else
      begin
         rx_valid_reg <= 1'b0;
         if (rx_clear)
         begin
            out_idx_reg <= QPD_CNT_RST;
         end
      end
   end

   assign rx_data = rx_data_reg;
   assign rx_valid = rx_valid_reg;
endmodule
`default_nettype wire

// ==== hdl/qpd_chip_end.sv ====
/*
 chipset end of the quad-pumped data bus; same data phase as the processor end,
 inverting every group that qualifies. assumes the same clocks and grant scheme.
*/
`timescale 1ns/100ps
`default_nettype none
module qpd_chip_end
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // bus lines
   qpd_fsb_if.chip fsb,
   // transmit side
   input wire qpd_pkg::qpd_word_t tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic bus_grant,
   // receive side
   output qpd_pkg::qpd_word_t rx_data,
   output logic rx_valid
);
   import qpd_pkg::*;

   qpd_pins_t pin_raw;
   qpd_pins_t s1_reg;
   qpd_pins_t s2_reg;
   qpd_pins_t s3_reg;
   qpd_word_t fifo_mem [QPD_FIFO_DEPTH];
   logic fifo_wr_reg;
   logic fifo_rd_reg;
   logic [1:0] fifo_cnt_reg;
   logic fifo_push;
   logic fifo_pop;
   qpd_word_t stage_mem [QPD_BEATS];
   logic [2:0] fill_reg;
   qpd_tx_t tx_state_reg;
   logic start;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   qpd_enc_t drv_reg;
   logic [QPD_GROUPS-1:0] stp_reg;
   logic [QPD_GROUPS-1:0] stn_reg;
   logic valid_n_reg;
   logic oe_n_reg;
   logic own_reg;
   qpd_word_t rx_word [QPD_BEATS];
   logic [2:0] grp_cnt_reg [QPD_GROUPS];
   logic [2:0] out_idx_reg;
   logic [QPD_GROUPS-1:0] take;
   logic rx_pending;
   logic rx_clear;

   assign pin_raw = {fsb.bus_clk, fsb.data_valid_indicator_n, fsb.data_strobe_neg_n,
                     fsb.data_strobe_pos_n, fsb.group_invert_flag_n, fsb.fsb_data_n};

   // third stage only feeds edge detection on the second
   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= '1;
         s2_reg <= '1;
         s3_reg <= '1;
      end
      else
      begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   assign tx_ready = fifo_cnt_reg != QPD_FIFO_FULL;
   assign fifo_push = tx_valid & tx_ready;
   assign fifo_pop = (fifo_cnt_reg != 2'h0) & (tx_state_reg == QPD_TX_GATHER);
   assign start = (tx_state_reg == QPD_TX_WAIT) & s2_reg.clk & ~s3_reg.clk & bus_grant;
   assign cnt_next = cnt_reg + 3'h1;

   always_ff @(posedge ref_clk)
   begin
      if (fifo_push)
      begin
         fifo_mem[fifo_wr_reg] <= tx_data;
      end
      if (fifo_pop)
      begin
         stage_mem[fill_reg[1:0]] <= fifo_mem[fifo_rd_reg];
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         fifo_wr_reg <= 1'b0;
         fifo_rd_reg <= 1'b0;
         fifo_cnt_reg <= 2'h0;
      end
      else
      begin
         fifo_wr_reg <= fifo_wr_reg ^ fifo_push;
         fifo_rd_reg <= fifo_rd_reg ^ fifo_pop;
         fifo_cnt_reg <= fifo_cnt_reg + {1'b0, fifo_push} - {1'b0, fifo_pop};
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         tx_state_reg <= QPD_TX_GATHER;
         fill_reg <= QPD_CNT_RST;
      end
      else
      begin
         case (tx_state_reg)
            QPD_TX_GATHER:
            begin
               fill_reg <= fill_reg + {2'h0, fifo_pop};
               if (fifo_pop && (fill_reg == QPD_FILL_LAST))
               begin
                  tx_state_reg <= QPD_TX_WAIT;
               end
            end
            QPD_TX_WAIT:
            begin
               if (start)
               begin
                  tx_state_reg <= QPD_TX_SEND;
               end
            end
            QPD_TX_SEND:
            begin
               if (cnt_reg == QPD_LAST_CYC)
               begin
                  tx_state_reg <= QPD_TX_GATHER;
                  fill_reg <= QPD_CNT_RST;
               end
            end
            default:
            begin
               tx_state_reg <= QPD_TX_GATHER;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_reg <= QPD_CNT_RST;
         drv_reg <= '1;
         stp_reg <= '1;
         stn_reg <= '1;
         valid_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
      end
      else if (start)
      begin
         cnt_reg <= QPD_CNT_RST;
         drv_reg <= qpd_encode(stage_mem[0], '1);
         valid_n_reg <= 1'b0;
         oe_n_reg <= 1'b0;
      end
      else if ((tx_state_reg == QPD_TX_SEND) && (cnt_reg != QPD_LAST_CYC))
      begin
         cnt_reg <= cnt_next;
         drv_reg <= qpd_encode(stage_mem[cnt_next[2:1]], '1);
         stp_reg <= {QPD_GROUPS{~qpd_pos_low(cnt_next)}};
         stn_reg <= {QPD_GROUPS{~qpd_neg_low(cnt_next)}};
      end
      else if (tx_state_reg == QPD_TX_SEND)
      begin
         stp_reg <= '1;
         stn_reg <= '1;
         valid_n_reg <= 1'b1;
         oe_n_reg <= 1'b1;
      end
   end

   assign {fsb.c_flag_n_o, fsb.c_data_n_o} = drv_reg;
   assign fsb.c_stp_n_o = stp_reg;
   assign fsb.c_stn_n_o = stn_reg;
   assign fsb.c_valid_n_o = valid_n_reg;
   assign fsb.c_oe_n = oe_n_reg;

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         own_reg <= 1'b0;
      end
      else if (start)
      begin
         own_reg <= 1'b1;
      end
      else if ((tx_state_reg != QPD_TX_SEND) && s2_reg.valid_n)
      begin
         own_reg <= 1'b0;
      end
   end

   always_comb
   begin
      rx_pending = 1'b1;
      for (int g = 0; g < QPD_GROUPS; g++)
      begin
         take[g] = ((s3_reg.stp_n[g] & ~s2_reg.stp_n[g]) | (s3_reg.stn_n[g] & ~s2_reg.stn_n[g]))
                   & ~s2_reg.valid_n & ~own_reg & (grp_cnt_reg[g] != QPD_BEAT_DONE);
         rx_pending = rx_pending & (grp_cnt_reg[g] > out_idx_reg);
      end
   end

   assign rx_clear = s2_reg.valid_n & ~rx_pending;

   always_ff @(posedge ref_clk)
   begin
      for (int g = 0; g < QPD_GROUPS; g++)
      begin
         if (take[g])
         begin
            rx_word[grp_cnt_reg[g][1:0]][g*QPD_GROUP_W +: QPD_GROUP_W] <=
               qpd_polarity(s2_reg.data_n[g*QPD_GROUP_W +: QPD_GROUP_W],
                            ~s2_reg.flag_n[g]);
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         for (int g = 0; g < QPD_GROUPS; g++)
         begin
            grp_cnt_reg[g] <= QPD_CNT_RST;
         end
         out_idx_reg <= QPD_CNT_RST;
         rx_data <= '0;
         rx_valid <= 1'b0;
      end
      else
      begin
         for (int g = 0; g < QPD_GROUPS; g++)
         begin
            if (rx_clear)
            begin
               grp_cnt_reg[g] <= QPD_CNT_RST;
            end
            else if (take[g])
            begin
               grp_cnt_reg[g] <= grp_cnt_reg[g] + 3'h1;
            end
         end
         rx_valid <= rx_pending;
         if (rx_pending)
         begin
            rx_data <= rx_word[out_idx_reg[1:0]];
            out_idx_reg <= out_idx_reg + 3'h1;
         end
         else if (rx_clear)
         begin
            out_idx_reg <= QPD_CNT_RST;
         end
      end
   end
endmodule
`default_nettype wire

// ==== bench/qpd_asserts.sv ====
/*
 checker on the shared data-phase lines.
 assumes one phase is 8 ref_clk cycles.
*/
`timescale 1ns/100ps
`default_nettype none
module qpd_asserts
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // lines
   input wire logic p_oe_n,
   input wire logic c_oe_n,
   input wire logic p_valid_n_o,
   input wire logic c_valid_n_o,
   input wire logic data_valid_indicator_n,
   input wire logic [3:0] data_strobe_pos_n,
   input wire logic [3:0] data_strobe_neg_n,
   input wire logic [3:0] group_invert_flag_n,
   input wire qpd_pkg::qpd_word_t fsb_data_n
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   AST_P_VALID: assert property (!p_oe_n |-> !p_valid_n_o)
   else $error("proc drives without valid");
   AST_C_VALID: assert property (!c_oe_n |-> !c_valid_n_o)
   else $error("chip drives without valid");
   AST_ONE_DRIVER: assert property (p_oe_n || c_oe_n)
   else $error("both ends drive");
   AST_PHASE_LEN: assert property ($fell(data_valid_indicator_n) |->
      !data_valid_indicator_n [*8] ##1 data_valid_indicator_n)
   else $error("phase not 8 cycles");
   AST_POS_FALLS: assert property ($fell(data_valid_indicator_n) |->
      ##1 $fell(data_strobe_pos_n[0]) ##4 $fell(data_strobe_pos_n[0]))
   else $error("positive strobe falls misplaced");
   AST_NEG_FALLS: assert property ($fell(data_valid_indicator_n) |->
      ##3 $fell(data_strobe_neg_n[0]) ##4 $fell(data_strobe_neg_n[0]))
   else $error("negative strobe falls misplaced");
   AST_PAIRS: assert property (data_strobe_pos_n == {4{data_strobe_pos_n[0]}} &&
      data_strobe_neg_n == {4{data_strobe_neg_n[0]}})
   else $error("strobe pairs differ");
   AST_IDLE: assert property (data_valid_indicator_n |->
      (data_strobe_pos_n & data_strobe_neg_n) == 4'hf)
   else $error("strobe low outside phase");
   for (genvar g = 0; g < 4; g++)
   begin : grp_chk
      AST_FLAG_CODE: assert property (!data_valid_indicator_n &&
         !group_invert_flag_n[g] |-> $countones(fsb_data_n[g*16 +: 16]) > 8)
      else $error("flagged group not mostly high");
   end
   cover property ($fell(data_valid_indicator_n) && !p_oe_n);
   cover property ($fell(data_valid_indicator_n) && !c_oe_n);
   cover property (!data_valid_indicator_n && group_invert_flag_n != 4'hf);
endmodule
`default_nettype wire

// ==== bench/tb_quad_pumped_data_bus_inversion.sv ====
/*
 bench joining both ends by one interface; index 0 is proc, 1 is chip.
 assumes the bench grants one end at a time.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_quad_pumped_data_bus_inversion;
   import qpd_pkg::*;
   logic ref_clk = 1'b0;
   logic bus_clk = 1'b0;
   logic rstn = 1'b0;
   qpd_word_t tx_data [2] = '{default: '0};
   logic tx_valid [2] = '{default: 1'b0};
   logic bus_grant [2] = '{default: 1'b0};
   logic tx_ready [2];
   qpd_word_t rx_data [2];
   logic rx_valid [2];
   logic [3:0] inv_en = 4'hf;
   qpd_word_t rxq [2][$];
   qpd_enc_t wq [$];
   qpd_word_t pat [$] = '{64'hffff_0000_01ff_00ff, 64'h0000_ffff_fe00_ff00,
      64'h0000_ffff_00ff_01ff, 64'h8001_7ffe_0000_ffff};
   int bad_count = 0;
   int cmp_count = 0;
   always #25 ref_clk = ~ref_clk;
   always #200 bus_clk = ~bus_clk;
   qpd_fsb_if qpd_fsb_if_inst (.bus_clk(bus_clk));
   qpd_proc_end qpd_proc_end_inst (.ref_clk(ref_clk), .rstn(rstn), .fsb(qpd_fsb_if_inst),
      .tx_data(tx_data[0]), .tx_valid(tx_valid[0]), .tx_ready(tx_ready[0]),
      .bus_grant(bus_grant[0]), .inv_en(inv_en), .rx_data(rx_data[0]), .rx_valid(rx_valid[0]));
   qpd_chip_end qpd_chip_end_inst (.ref_clk(ref_clk), .rstn(rstn), .fsb(qpd_fsb_if_inst),
      .tx_data(tx_data[1]), .tx_valid(tx_valid[1]), .tx_ready(tx_ready[1]),
      .bus_grant(bus_grant[1]), .rx_data(rx_data[1]), .rx_valid(rx_valid[1]));
   qpd_asserts qpd_asserts_inst (.ref_clk(ref_clk), .rstn(rstn),
      .p_oe_n(qpd_fsb_if_inst.p_oe_n), .c_oe_n(qpd_fsb_if_inst.c_oe_n),
      .p_valid_n_o(qpd_fsb_if_inst.p_valid_n_o), .c_valid_n_o(qpd_fsb_if_inst.c_valid_n_o),
      .data_valid_indicator_n(qpd_fsb_if_inst.data_valid_indicator_n),
      .data_strobe_pos_n(qpd_fsb_if_inst.data_strobe_pos_n),
      .data_strobe_neg_n(qpd_fsb_if_inst.data_strobe_neg_n),
      .group_invert_flag_n(qpd_fsb_if_inst.group_invert_flag_n),
      .fsb_data_n(qpd_fsb_if_inst.fsb_data_n));
   always @(posedge ref_clk)
      for (int e = 0; e < 2; e++)
         if (rx_valid[e] === 1'b1)
            rxq[e].push_back(rx_data[e]);
   // every strobe fall is one beat on the wire
   always @(negedge qpd_fsb_if_inst.data_strobe_pos_n[0] or
            negedge qpd_fsb_if_inst.data_strobe_neg_n[0])
      if (qpd_fsb_if_inst.data_valid_indicator_n === 1'b0)
         wq.push_back({qpd_fsb_if_inst.group_invert_flag_n, qpd_fsb_if_inst.fsb_data_n});
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(string what, logic [67:0] exp, logic [67:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic qpd_enc_t wire_of(qpd_word_t w, logic [3:0] en);
      logic [15:0] d;
      logic inv;
      for (int g = 0; g < 4; g++)
      begin
         d = w[g*16 +: 16];
         inv = en[g] && ($countones(d) > 8);
         wire_of[64+g] = ~inv;
         wire_of[g*16 +: 16] = inv ? d : ~d;
      end
   endfunction
   // holds valid until the edge that sees ready, then leaves it for the caller
   task automatic push(int e, qpd_word_t w);
      tx_data[e] <= w;
      tx_valid[e] <= 1'b1;
      #1;
      while (tx_ready[e] !== 1'b1)
         @(posedge ref_clk) #1;
      @(posedge ref_clk);
   endtask
   task automatic run(int e, logic [3:0] en, qpd_word_t w[$]);
      rxq[0].delete();
      rxq[1].delete();
      wq.delete();
      inv_en <= en;
      foreach (w[i])
      begin
         if (i == 6)
         begin
            repeat (3) @(posedge ref_clk);
            #1;
            check("tx_ready full", 68'h0, {67'h0, tx_ready[e]});
            @(posedge ref_clk);
            bus_grant[e] <= 1'b1;
         end
         push(e, w[i]);
      end
      tx_valid[e] <= 1'b0;
      bus_grant[e] <= 1'b1;
      for (int i = 0; i < 2000 && rxq[1-e].size() < w.size(); i++)
         @(posedge ref_clk);
      bus_grant[e] <= 1'b0;
      repeat (20) @(posedge ref_clk);
      check("rx count", 68'(w.size()), 68'(rxq[1-e].size()));
      check("echo count", 68'h0, 68'(rxq[e].size()));
      foreach (w[i])
      begin
         check("rx word", {4'h0, w[i]}, {4'h0, rxq[1-e][i]});
         check("wire beat", wire_of(w[i], en), wq[i]);
      end
   endtask
   task automatic t_proc_all();
      run(0, 4'hf, pat);
   endtask
   task automatic t_proc_mask();
      run(0, 4'h5, pat);
   endtask
   // two phases back to back, buffer full while no grant
   task automatic t_chip_full();
      qpd_word_t q[$];
      q = pat;
      foreach (pat[i])
         q.push_back(~pat[i]);
      run(1, 4'hf, q);
   endtask
   initial
   begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      t_proc_all();
      t_proc_mask();
      t_chip_full();
      conclude();
   end
   initial
   begin
      #2000000;
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
